// >>> ext_trigger_acq_strobe_timer.sv
`timescale 1ns/1ns
// Function
// - Edge mode: trigger rising edge starts a cycle.
// - Busy, acquisition delay, integrate, final busy, end.
// - Acquisition delay 1 us steps adds to busy.
// - Edge mode integration from register, 10 us steps.
// - Single strobe rises after delay, lasts width.
// - Single strobe forced low at integration end.
// - Continuous strobe toggles only during integration.
// - Edge mode emits only complete strobe periods.
// - Period in 10 us steps, active if shorter.
// - Level mode integration equals trigger high time.
// - Short level pulse flags error, zero spectrum.
// - Level mode forces strobe low at end.
// - Level mode edge starts busy then delay.
// - Fifty percent duty; edge mode stops before unfinished period.
// - Spectrum returned before next trigger accepted.
// - Disabled single strobe stays low always.
module ext_trigger_acq_strobe_timer #(
    parameter int TICK_CYC = acq_timer_pkg::TICK_CYCLES,
    parameter int BUSY1_US = acq_timer_pkg::INITIAL_BUSY_US,
    parameter int BUSY2_US = acq_timer_pkg::FINAL_BUSY_US
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Trigger input and strobe outputs.
    input wire logic ext_trigger,
    output logic single_strobe,
    output logic cont_strobe,
    // Readout handshake with the detector transfer logic.
    output logic readout_req,
    output logic zero_spectrum,
    input wire logic readout_done
);
    // Configuration and state registers.
    acq_timer_pkg::cfg_t cfg_reg;
    acq_timer_pkg::seq_state_t state_reg, state_next;
    logic [31:0] prdata_reg;
    logic err_reg;
    logic trig_q_reg;
    logic event_reg;
    logic [7:0] tick_cnt_reg;
    logic [23:0] ph_us_reg;
    logic [23:0] ss_us_reg;
    logic [1:0] ss_ph_reg;
    logic [23:0] cs_us_reg;
    logic cs_run_reg;
    logic [23:0] lvl_us_reg;
    logic lvl_fell_reg;
    logic ss_out_reg;
    logic cs_out_reg;

    // Bus decode.
    wire setup = psel && !penable;
    wire acc = psel && penable;
    wire hit_ctrl = (paddr == acq_timer_pkg::CTRL_OFS);
    wire hit_acq = (paddr == acq_timer_pkg::ACQ_DLY_OFS);
    wire hit_int = (paddr == acq_timer_pkg::INTEG_OFS);
    wire hit_ssd = (paddr == acq_timer_pkg::SS_DLY_OFS);
    wire hit_ssw = (paddr == acq_timer_pkg::SS_WID_OFS);
    wire hit_csp = (paddr == acq_timer_pkg::CS_PER_OFS);
    wire hit_st = (paddr == acq_timer_pkg::STATUS_OFS);
    wire hit_lvl = (paddr == acq_timer_pkg::LVL_WID_OFS);
    wire mapped = hit_ctrl | hit_acq | hit_int | hit_ssd | hit_ssw | hit_csp | hit_st | hit_lvl;
    wire wr = acc && pwrite && mapped;
    wire busy = (state_reg != acq_timer_pkg::ST_IDLE);
    wire [31:0] ctrl_rd = {29'h0, cfg_reg.cs_en, cfg_reg.ss_en, cfg_reg.level_mode};
    wire [31:0] st_rd = {27'h0, err_reg, busy, state_reg};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
                         hit_acq ? {8'h0, cfg_reg.acq_dly_us} :
                         hit_int ? {8'h0, cfg_reg.integ_10us} :
                         hit_ssd ? {8'h0, cfg_reg.ss_dly_us} :
                         hit_ssw ? {8'h0, cfg_reg.ss_wid_us} :
                         hit_csp ? {8'h0, cfg_reg.cs_per_10us} :
                         hit_st ? st_rd :
                         hit_lvl ? {8'h0, lvl_us_reg} : 32'h0;
    assign pready = acc;
    assign pslverr = acc && !mapped;
    assign prdata = prdata_reg;

    // Microsecond tick and the derived interval limits.
    wire tick = (tick_cnt_reg == 8'(TICK_CYC - 1));
    wire rise = ext_trigger && !trig_q_reg;
    wire [23:0] integ_us = 24'(cfg_reg.integ_10us * acq_timer_pkg::INTEG_STEP_US);
    wire [23:0] per_us = 24'(cfg_reg.cs_per_10us * acq_timer_pkg::CS_STEP_US);
    wire [23:0] half_us = {1'b0, per_us[23:1]};
    wire [23:0] left_us = integ_us - ph_us_reg;
    wire lvl_short = lvl_us_reg < 24'(acq_timer_pkg::INTEG_MIN_US);
    // Same end-point rule as the edge mode, so integration lasts exactly the measured width.
    wire lvl_end = lvl_fell_reg && (ph_us_reg + 24'h000001 >= lvl_us_reg);
    wire lvl_cap = ph_us_reg >= 24'(acq_timer_pkg::INTEG_MAX_US);
    wire integ_end = tick && (cfg_reg.level_mode ? (lvl_end || lvl_cap)
                                                 : (ph_us_reg + 24'h000001 >= integ_us));
    wire cs_ok = (per_us != 24'h0) && (per_us < integ_us || cfg_reg.level_mode);
    wire leaving_integ = (state_reg == acq_timer_pkg::ST_INTEG) && integ_end;

    // Sequencer next state.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            acq_timer_pkg::ST_IDLE:
            begin
                // The trigger event is registered one clock after the rising edge is seen.
                if (event_reg)
                    state_next = acq_timer_pkg::ST_BUSY1;
            end
            acq_timer_pkg::ST_BUSY1:
            begin
                if (tick && ph_us_reg + 24'h000001 >= 24'(BUSY1_US))
                    state_next = (cfg_reg.acq_dly_us == 24'h0) ? acq_timer_pkg::ST_INTEG
                                                              : acq_timer_pkg::ST_ACQDLY;
            end
            acq_timer_pkg::ST_ACQDLY:
            begin
                if (tick && ph_us_reg + 24'h000001 >= cfg_reg.acq_dly_us)
                    state_next = acq_timer_pkg::ST_INTEG;
            end
            acq_timer_pkg::ST_INTEG:
            begin
                if (integ_end)
                    state_next = acq_timer_pkg::ST_BUSY2;
            end
            acq_timer_pkg::ST_BUSY2:
            begin
                if (tick && ph_us_reg + 24'h000001 >= 24'(BUSY2_US))
                    state_next = acq_timer_pkg::ST_RETURN;
            end
            acq_timer_pkg::ST_RETURN:
            begin
                // No new trigger until the transfer logic reports the spectrum sent.
                if (readout_done)
                    state_next = acq_timer_pkg::ST_IDLE;
            end
            default:
                state_next = acq_timer_pkg::ST_IDLE;
        endcase
    end

    // Bus registers; writes are taken in any state and act at once on running counters.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_reg <= {acq_timer_pkg::CTRL_RST, acq_timer_pkg::ACQ_DLY_RST,
                        acq_timer_pkg::INTEG_RST, acq_timer_pkg::SS_DLY_RST,
                        acq_timer_pkg::SS_WID_RST, acq_timer_pkg::CS_PER_RST};
            prdata_reg <= 32'h0;
        end
        else
        begin
            if (setup)
                prdata_reg <= rd_mux;
            if (wr && hit_ctrl)
                {cfg_reg.cs_en, cfg_reg.ss_en, cfg_reg.level_mode} <= pwdata[2:0];
            if (wr && hit_acq)
                cfg_reg.acq_dly_us <= pwdata[23:0];
            if (wr && hit_int)
                cfg_reg.integ_10us <= pwdata[23:0];
            if (wr && hit_ssd)
                cfg_reg.ss_dly_us <= pwdata[23:0];
            if (wr && hit_ssw)
                cfg_reg.ss_wid_us <= pwdata[23:0];
            if (wr && hit_csp)
                cfg_reg.cs_per_10us <= pwdata[23:0];
        end
    end

    // Error flag: a short pulse sets it, a set beats a same-cycle clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            err_reg <= 1'b0;
        else if (leaving_integ && cfg_reg.level_mode && lvl_short)
            err_reg <= 1'b1;
        else if (wr && hit_st && pwdata[acq_timer_pkg::STAT_ERR_BIT])
            err_reg <= 1'b0;
    end

    // Trigger sampling, tick divider, sequencer and phase timer.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trig_q_reg <= 1'b0;
            event_reg <= 1'b0;
            tick_cnt_reg <= 8'h0;
            state_reg <= acq_timer_pkg::ST_IDLE;
            ph_us_reg <= 24'h0;
        end
        else
        begin
            trig_q_reg <= ext_trigger;
            // Edges while busy are dropped outright rather than queued.
            event_reg <= rise && !busy && !event_reg;
            // The tick restarts at the event so intervals start on a whole microsecond.
            tick_cnt_reg <= (tick || event_reg) ? 8'h0 : tick_cnt_reg + 8'h01;
            state_reg <= state_next;
            if (state_next != state_reg)
                ph_us_reg <= 24'h0;
            else if (tick)
                ph_us_reg <= ph_us_reg + 24'h000001;
        end
    end

    // Level pulse width measured from the event until the trigger falls.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lvl_us_reg <= 24'h0;
            lvl_fell_reg <= 1'b0;
        end
        else if (event_reg)
        begin
            lvl_us_reg <= 24'h0;
            lvl_fell_reg <= 1'b0;
        end
        else if (busy && !lvl_fell_reg)
        begin
            if (!ext_trigger)
                lvl_fell_reg <= 1'b1;
            else if (tick)
                lvl_us_reg <= lvl_us_reg + 24'h000001;
        end
    end

    // Single strobe: phase 0 waits the delay, 1 is high, 2 is finished.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ss_us_reg <= 24'h0;
            ss_ph_reg <= 2'h2;
            ss_out_reg <= 1'b0;
        end
        else if (event_reg)
        begin
            ss_us_reg <= 24'h0;
            ss_ph_reg <= 2'h0;
            ss_out_reg <= 1'b0;
        end
        else if (leaving_integ || state_reg == acq_timer_pkg::ST_BUSY2)
        begin
            // Integration end cuts the pulse short whatever the width.
            ss_ph_reg <= 2'h2;
            ss_out_reg <= 1'b0;
        end
        else if (ss_ph_reg == 2'h0 && ss_us_reg >= cfg_reg.ss_dly_us)
        begin
            ss_us_reg <= 24'h0;
            ss_ph_reg <= (cfg_reg.ss_wid_us == 24'h0) ? 2'h2 : 2'h1;
            ss_out_reg <= (cfg_reg.ss_wid_us != 24'h0) && cfg_reg.ss_en;
        end
        else if (ss_ph_reg == 2'h1 && ss_us_reg >= cfg_reg.ss_wid_us)
        begin
            ss_ph_reg <= 2'h2;
            ss_out_reg <= 1'b0;
        end
        else
        begin
            if (tick && ss_ph_reg != 2'h2)
                ss_us_reg <= ss_us_reg + 24'h000001;
            ss_out_reg <= ss_out_reg && cfg_reg.ss_en;
        end
    end

    // Continuous strobe: high for the first half of each period.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cs_us_reg <= 24'h0;
            cs_run_reg <= 1'b0;
            cs_out_reg <= 1'b0;
        end
        else if (state_reg != acq_timer_pkg::ST_INTEG || leaving_integ)
        begin
            // Low outside integration; in level mode this truncates a period.
            cs_us_reg <= 24'h0;
            cs_run_reg <= (state_next == acq_timer_pkg::ST_INTEG) && cs_ok;
            cs_out_reg <= 1'b0;
        end
        else if (cs_run_reg)
        begin
            if (cs_us_reg == 24'h0 && !cfg_reg.level_mode && left_us < per_us)
            begin
                // Not enough time left for a whole period: stay low to the end.
                cs_run_reg <= 1'b0;
                cs_out_reg <= 1'b0;
            end
            else
            begin
                cs_out_reg <= cfg_reg.cs_en && (cs_us_reg < half_us);
                if (tick)
                    cs_us_reg <= (cs_us_reg + 24'h000001 >= per_us) ? 24'h0
                                 : cs_us_reg + 24'h000001;
            end
        end
        else
            cs_out_reg <= 1'b0;
    end

    // Strobe and readout outputs.
    assign single_strobe = ss_out_reg;
    assign cont_strobe = cs_out_reg;
    assign readout_req = (state_reg == acq_timer_pkg::ST_RETURN);
    assign zero_spectrum = err_reg;
endmodule

// >>> acq_timer_pkg.sv
package acq_timer_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] ACQ_DLY_OFS = 8'h04;
    localparam logic [7:0] INTEG_OFS = 8'h08;
    localparam logic [7:0] SS_DLY_OFS = 8'h0C;
    localparam logic [7:0] SS_WID_OFS = 8'h10;
    localparam logic [7:0] CS_PER_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    localparam logic [7:0] LVL_WID_OFS = 8'h1C;
    // Control field positions.
    localparam int CTRL_LEVEL_BIT = 0;
    localparam int CTRL_SS_EN_BIT = 1;
    localparam int CTRL_CS_EN_BIT = 2;
    // Status field positions; the error flag is write-one-to-clear.
    localparam int STAT_BUSY_BIT = 3;
    localparam int STAT_ERR_BIT = 4;
    // Reset values of the configuration registers.
    localparam logic [2:0] CTRL_RST = 3'h2;
    localparam logic [23:0] ACQ_DLY_RST = 24'h000000;
    localparam logic [23:0] INTEG_RST = 24'h000186;
    localparam logic [23:0] SS_DLY_RST = 24'h000000;
    localparam logic [23:0] SS_WID_RST = 24'h000000;
    localparam logic [23:0] CS_PER_RST = 24'h000000;
    // Times in microseconds and the clock rate.
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int TICK_CYCLES = US_NS / CLK_PERIOD_NS;
    localparam int INITIAL_BUSY_US = 1561;
    localparam int FINAL_BUSY_US = 1553;
    localparam int ACQ_DLY_MAX_US = 335500;
    localparam int INTEG_MIN_US = 3800;
    localparam int INTEG_MAX_US = 6000000;
    localparam int INTEG_STEP_US = 10;
    localparam int CS_STEP_US = 10;
    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_BUSY1 = 3'b001,
        ST_ACQDLY = 3'b010,
        ST_INTEG = 3'b011,
        ST_BUSY2 = 3'b100,
        ST_RETURN = 3'b101
    } seq_state_t;
    // Configuration written by software.
    typedef struct packed {
        logic level_mode;
        logic ss_en;
        logic cs_en;
        logic [23:0] acq_dly_us;
        logic [23:0] integ_10us;
        logic [23:0] ss_dly_us;
        logic [23:0] ss_wid_us;
        logic [23:0] cs_per_10us;
    } cfg_t;
endpackage

// >>> acq_timer_assertions.sv
`timescale 1ns/1ns
// Pin-level checks on the timer; it sees only the top-level ports.
module acq_timer_checker #(
    parameter int TICK_CYC = 2,
    parameter int BUSY1_US = 5,
    parameter int BUSY2_US = 5
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Bus handshake.
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Strobes and readout handshake.
    input wire logic single_strobe,
    input wire logic cont_strobe,
    input wire logic readout_req,
    input wire logic zero_spectrum,
    input wire logic readout_done
);
    // One clock domain, so one clocking and one disable serve all checks.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_reset_quiet;
        $rose(presetn) |-> !single_strobe && !cont_strobe && !readout_req && !zero_spectrum;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not low after reset");
    // Both strobes must have been low four clocks before the readout request rose.
    property p_busy2_quiet;
        $rose(readout_req) |-> $past(cont_strobe, 4) == 1'b0 && $past(single_strobe, 4) == 1'b0;
    endproperty
    a_busy2_quiet: assert property (p_busy2_quiet)
        else $error("strobe active during final busy");
    property p_cs_return;
        readout_req |-> !cont_strobe;
    endproperty
    a_cs_return: assert property (p_cs_return)
        else $error("continuous strobe outside integration");
    property p_ss_return;
        readout_req |-> !single_strobe;
    endproperty
    a_ss_return: assert property (p_ss_return)
        else $error("single strobe after integration");
    property p_req_hold;
        readout_req && !readout_done |=> readout_req;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("readout dropped early");
    property p_req_end;
        readout_req && readout_done |=> !readout_req;
    endproperty
    a_req_end: assert property (p_req_end)
        else $error("readout not ended by done");
    // The error flag only clears through a bus write.
    property p_zero_sticky;
        zero_spectrum && !psel |=> zero_spectrum;
    endproperty
    a_zero_sticky: assert property (p_zero_sticky)
        else $error("error flag lost");
    property p_pready;
        psel && penable |-> pready;
    endproperty
    a_pready: assert property (p_pready)
        else $error("no ready in access phase");
    property p_pslverr;
        pslverr |-> psel && penable;
    endproperty
    a_pslverr: assert property (p_pslverr)
        else $error("error outside access phase");
endmodule

bind ext_trigger_acq_strobe_timer acq_timer_checker #(
    .TICK_CYC(TICK_CYC),
    .BUSY1_US(BUSY1_US),
    .BUSY2_US(BUSY2_US)
) u_acq_timer_checker (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .single_strobe, .cont_strobe, .readout_req, .zero_spectrum, .readout_done);

// >>> trig_source.sv
`timescale 1ns/1ns
// Stand-in for the external source that drives the trigger pin.
module trig_source (
    // Clock.
    input wire logic pclk,
    // Trigger pin.
    output logic ext_trigger
);
    // The pin is push-pull and idles low.
    initial ext_trigger = 1'b0;

    // One high pulse of hi_cyc clocks, launched just after an edge.
    task automatic pulse(input int hi_cyc);
        @(posedge pclk);
        ext_trigger <= 1'b1;
        // A full clock at least, so the minimum high time always holds.
        repeat ((hi_cyc < 1) ? 1 : hi_cyc) @(posedge pclk);
        ext_trigger <= 1'b0;
    endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ns
// Self-checking bench; short counts keep the run brief.
module testbench;
    localparam int TK = 2;
    localparam int B1 = 5;
    localparam int B2 = 5;
    // Bus, pin and bench signals.
    logic pclk, presetn, psel, penable, pwrite, readout_done, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, ext_trigger, single_strobe, cont_strobe, readout_req, zero_spectrum;
    int num_errors = 0;
    int check_count = 0;
    logic [31:0] seed = 32'h0000EB69;
    // Reset values of all eight mapped registers.
    logic [31:0] rst [8] = '{32'h2, 32'h0, 32'h186, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

    ext_trigger_acq_strobe_timer #(.TICK_CYC(TK), .BUSY1_US(B1), .BUSY2_US(B2))
    u_ext_trigger_acq_strobe_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ext_trigger, .single_strobe, .cont_strobe,
        .readout_req, .zero_spectrum, .readout_done);
    trig_source u_trig_source (.pclk, .ext_trigger);

    // Free-running 100 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Xorshift source of stimulus values.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Compares and counts; four-state equality so unknowns fail.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: saw %0d, expected %0d", $time, seen, exp);
        end
    endtask

    // Timings carry a few clocks of latency, so they pass within a tolerance.
    task automatic near(input int seen, input int exp, input int tol);
        check((seen - exp <= tol && exp - seen <= tol) ? exp : seen, exp);
    endtask

    // One bus transfer; the request holds until ready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for ready.
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Prints counts and the verdict; the single place the run ends.
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Programs, triggers and measures one acquisition against the model.
    task automatic cycle(input int lvl, acq, integ, ssd, ssw, cp, ssen, csen, w);
        int t, t_ss, hi, n, istart, ilen, iend, per, e_hi, e_n;
        int v [5];
        logic prev;
        t = 0;
        t_ss = -1;
        hi = 0;
        n = 0;
        prev = 1'b0;
        v = '{acq, integ, ssd, ssw, cp};
        apb(1'b1, acq_timer_pkg::CTRL_OFS, {29'h0, csen[0], ssen[0], lvl[0]});
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, 8'(4 * i + 4), v[i]);
            apb(1'b0, 8'(4 * i + 4), 0);
            check(rd, v[i]);
        end
        fork
            u_trig_source.pulse(w);
        join_none
        do
        begin
            @(posedge pclk);
            #1;
            t++;
            if (single_strobe === 1'b1)
            begin
                hi++;
                if (t_ss < 0)
                    t_ss = t;
            end
            if (cont_strobe === 1'b1 && !prev)
                n++;
            prev = cont_strobe;
            // A second edge while busy must not disturb the cycle.
            if (t == 30 && lvl == 0)
            begin
                // Forked so that the sampling loop keeps counting every clock.
                fork
                    u_trig_source.pulse(2);
                join_none
            end
        end while (readout_req !== 1'b1 && t < 20000);
        // A loop that ran out of time counts as a mismatch here.
        check(readout_req, 1);
        istart = 2 + (B1 + acq) * TK;
        ilen = lvl ? w - 2 : integ * 10 * TK;
        iend = istart + ilen;
        per = cp * 10 * TK;
        e_hi = (ssen && ssw > 0 && 2 + ssd * TK < iend) ? iend - 2 - ssd * TK : 0;
        e_hi = (e_hi > ssw * TK) ? ssw * TK : e_hi;
        e_n = (!csen || cp == 0 || (!lvl && cp >= integ)) ? 0 : lvl ? (ilen + per - 1) / per
            : ilen / per;
        near(t, iend + B2 * TK, 4);
        near(hi, e_hi, 4);
        if (e_hi > 0)
            near(t_ss, 2 + ssd * TK, 4);
        near(n, e_n, lvl);
        check(zero_spectrum, lvl && ilen / TK < 3800);
        fork
            u_trig_source.pulse(2);
        join_none
        repeat (6) @(posedge pclk);
        readout_done <= 1'b1;
        @(posedge pclk);
        readout_done <= 1'b0;
        repeat (4) @(posedge pclk);
        check(readout_req, 0);
        apb(1'b0, acq_timer_pkg::STATUS_OFS, 0);
        check(rd & 32'h7, 0);
        if (lvl)
        begin
            apb(1'b0, acq_timer_pkg::LVL_WID_OFS, 0);
            check(rd, (w - 2) / TK);
            apb(1'b1, acq_timer_pkg::STATUS_OFS, 32'h10);
            // The clear lands at the access edge; look once it has settled.
            #1;
            check(zero_spectrum, 0);
        end
    endtask

    // Watchdog, well beyond the expected run length.
    initial
    begin
        #1000000;
        num_errors++;
        complete_run();
    end

    // Main sequence.
    initial
    begin
        {presetn, psel, penable, pwrite, readout_done, paddr, pwdata} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        check({single_strobe, cont_strobe, readout_req, zero_spectrum}, 0);
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b0, 8'(4 * i), 0);
            check(rd, rst[i]);
        end
        // An unmapped address answers with an error and reads zero.
        apb(1'b0, 8'h20, 0);
        check(err, 1);
        check(rd, 0);
        cycle(0, 3, 390, 2, 4, 7, 1, 1, 2);
        repeat (6)
            cycle(0, rnd() % 16, 5 + rnd() % 10, rnd() % 8, rnd() % 6, rnd() % 4,
                rnd() % 2, rnd() % 2, 1 + rnd() % 3);
        cycle(0, 0, 6, 1, 100000, 6, 1, 1, 1);
        cycle(1, 2, 0, 3, 9, 7, 1, 1, 7800);
        cycle(1, 5, 0, 0, 20000, 2, 1, 1, 400);
        complete_run();
    end
endmodule
